// ===== src/scfg_bank.v
// System configuration bank: DMA request selects, pin filters and I2C pad modes
//
// Functional notes
// - Offset 0x0C bits 21:16 hold the channel 7 request select, reset to all ones.
// - Bits 13:8 of that register hold the channel 6 request select, reset to all ones.
// - Bits 5:0 hold the channel 5 select; the register resets to 0x003F3F3F.
// - Each select routes one request from codes 0 to 0x32 to its channel.
// - Offset 0x10 holds sixteen port A filter enables, reset to zero.
// - Offset 0x14 holds sixteen port B filter enables, reset to zero.
// - Offset 0x18 holds sixteen port C filter enables, reset to zero.
// - Offset 0x1C holds ten port F filter enables for pins 0 to 9, reset to zero.
// - Offset 0x20 bits 25:24 select I2C pad mode on port F pins 3 and 4.
// - Bits 15:8 select I2C pad mode on port B pins 6,7,8,9,10,11,13,14.
// - Bits 1:0 select I2C pad mode on port A pins 9 and 10.
`timescale 1ns/1ns
`include "scfg_consts.vh"
module scfg_bank #(
  parameter NREQ = 51,
  parameter CNT_W = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [`SCFG_ADDR_W-1:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // DMA request routing
  input wire [NREQ-1:0] periph_req_i,
  output wire ch5_req_o,
  output wire ch6_req_o,
  output wire ch7_req_o,
  // Pad inputs and filtered levels
  input wire [15:0] port_a_pin_i,
  input wire [15:0] port_b_pin_i,
  input wire [15:0] port_c_pin_i,
  input wire [`SCFG_FLT_F_W-1:0] port_f_pin_i,
  output wire [15:0] port_a_level_o,
  output wire [15:0] port_b_level_o,
  output wire [15:0] port_c_level_o,
  output wire [`SCFG_FLT_F_W-1:0] port_f_level_o,
  // Pad mode controls
  output wire [1:0] port_f_i2c_pad_select_o,
  output wire [7:0] port_b_i2c_pad_select_o,
  output wire [1:0] port_a_i2c_pad_select_o
);
  // Filter length in clock cycles, cut to the counter width on purpose
  localparam [31:0] HOLD_WORD = `SCFG_FILTER_CYC;
  localparam [CNT_W-1:0] HOLD = HOLD_WORD[CNT_W-1:0];
  // Reset image of the whole request select register
  localparam [31:0] DMA_SEL_RST = `SCFG_DMA_SEL_RST;

  // Register map by byte offset on the register port:
  //   0x0C request selects of channels 7, 6 and 5
  //   0x10 port A filter enables
  //   0x14 port B filter enables
  //   0x18 port C filter enables
  //   0x1C port F filter enables, pins 0 to 9
  //   0x20 I2C pad mode selects of ports F, B and A
  // Any other offset reads zero and drops writes
  // DMA request selects
  reg [5:0] channel7_request_select_reg;
  reg [5:0] channel6_request_select_reg;
  reg [5:0] channel5_request_select_reg;
  // Pin filter enables
  reg [15:0] flt_a_reg;
  reg [15:0] flt_b_reg;
  reg [15:0] flt_c_reg;
  reg [`SCFG_FLT_F_W-1:0] flt_f_reg;
  // I2C pad mode selects
  reg [1:0] pf_i2c_reg;
  reg [7:0] pb_i2c_reg;
  reg [1:0] pa_i2c_reg;
  // Read path
  reg [31:0] rdata_next;
  wire [31:0] dma_sel_word;
  wire [31:0] i2c_word;
  wire [31:0] flt_a_word;
  wire [31:0] flt_b_word;
  wire [31:0] flt_c_word;
  wire [31:0] flt_f_word;
  // Write strobes per register
  wire wr_dma_sel;
  wire wr_flt_a;
  wire wr_flt_b;
  wire wr_flt_c;
  wire wr_flt_f;
  wire wr_i2c;
  // Select codes that name a request
  wire ch5_sel_valid;
  wire ch6_sel_valid;
  wire ch7_sel_valid;

  // Write strobes decoded per register
  // Unmapped offsets match none, so such writes are dropped
  assign wr_dma_sel = wr_i && (addr_i == `SCFG_OFS_DMA_SEL);
  assign wr_flt_a = wr_i && (addr_i == `SCFG_OFS_FLT_A);
  assign wr_flt_b = wr_i && (addr_i == `SCFG_OFS_FLT_B);
  assign wr_flt_c = wr_i && (addr_i == `SCFG_OFS_FLT_C);
  assign wr_flt_f = wr_i && (addr_i == `SCFG_OFS_FLT_F);
  assign wr_i2c = wr_i && (addr_i == `SCFG_OFS_I2C);

  // DMA request selects
  // Reserved bits 31:22, 15:14 and 7:6 have no storage
  always @(posedge clk_i) begin
    if (rst_i) begin
      channel7_request_select_reg <= DMA_SEL_RST[`SCFG_CH7_LSB +: `SCFG_SEL_W];
      channel6_request_select_reg <= DMA_SEL_RST[`SCFG_CH6_LSB +: `SCFG_SEL_W];
      channel5_request_select_reg <= DMA_SEL_RST[`SCFG_CH5_LSB +: `SCFG_SEL_W];
    end else if (wr_dma_sel) begin
      channel7_request_select_reg <= wdata_i[`SCFG_CH7_LSB +: `SCFG_SEL_W];
      channel6_request_select_reg <= wdata_i[`SCFG_CH6_LSB +: `SCFG_SEL_W];
      channel5_request_select_reg <= wdata_i[`SCFG_CH5_LSB +: `SCFG_SEL_W];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flt_a_reg <= `SCFG_FLT_RST;
    end else if (wr_flt_a) begin
      flt_a_reg <= wdata_i[15:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flt_b_reg <= `SCFG_FLT_RST;
    end else if (wr_flt_b) begin
      flt_b_reg <= wdata_i[15:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      flt_c_reg <= `SCFG_FLT_RST;
    end else if (wr_flt_c) begin
      flt_c_reg <= wdata_i[15:0];
    end
  end

  // port F filter enables, pins 0 to 9
  always @(posedge clk_i) begin
    if (rst_i) begin
      flt_f_reg <= {`SCFG_FLT_F_W{1'b0}};
    end else if (wr_flt_f) begin
      flt_f_reg <= wdata_i[`SCFG_FLT_F_W-1:0];
    end
  end

  // I2C pad mode selects
  // Reserved bits 31:26, 23:16 and 7:2 have no storage
  always @(posedge clk_i) begin
    if (rst_i) begin
      pf_i2c_reg <= 2'h0;
      pb_i2c_reg <= 8'h00;
      pa_i2c_reg <= 2'h0;
    end else if (wr_i2c) begin
      pf_i2c_reg <= wdata_i[`SCFG_PF_I2C_LSB +: 2];
      pb_i2c_reg <= wdata_i[`SCFG_PB_I2C_LSB +: 8];
      pa_i2c_reg <= wdata_i[`SCFG_PA_I2C_LSB +: 2];
    end
  end

  // Packed read words with reserved bits at zero
  assign dma_sel_word = {10'h000, channel7_request_select_reg, 2'h0, channel6_request_select_reg,
                         2'h0, channel5_request_select_reg};
  assign i2c_word = {6'h00, pf_i2c_reg, 8'h00, pb_i2c_reg, 6'h00, pa_i2c_reg};
  assign flt_a_word = {16'h0000, flt_a_reg};
  assign flt_b_word = {16'h0000, flt_b_reg};
  assign flt_c_word = {16'h0000, flt_c_reg};
  assign flt_f_word = {{(32-`SCFG_FLT_F_W){1'b0}}, flt_f_reg};

  always @* begin
    rdata_next = 32'h00000000;
    if (addr_i == `SCFG_OFS_DMA_SEL) begin
      rdata_next = dma_sel_word;
    end else if (addr_i == `SCFG_OFS_FLT_A) begin
      rdata_next = flt_a_word;
    end else if (addr_i == `SCFG_OFS_FLT_B) begin
      rdata_next = flt_b_word;
    end else if (addr_i == `SCFG_OFS_FLT_C) begin
      rdata_next = flt_c_word;
    end else if (addr_i == `SCFG_OFS_FLT_F) begin
      rdata_next = flt_f_word;
    end else if (addr_i == `SCFG_OFS_I2C) begin
      rdata_next = i2c_word;
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // request multiplexer; reserved codes give no request
  function route;
    input [5:0] sel;
    input [NREQ-1:0] req;
    begin
      route = 1'b0;
      if (sel < NREQ) begin
        route = req[sel];
      end
    end
  endfunction

  // codes above the last listed request are reserved
  assign ch5_sel_valid = (channel5_request_select_reg <= `SCFG_SEL_MAX);
  assign ch6_sel_valid = (channel6_request_select_reg <= `SCFG_SEL_MAX);
  assign ch7_sel_valid = (channel7_request_select_reg <= `SCFG_SEL_MAX);

  assign ch5_req_o = ch5_sel_valid & route(channel5_request_select_reg, periph_req_i);
  assign ch6_req_o = ch6_sel_valid & route(channel6_request_select_reg, periph_req_i);
  assign ch7_req_o = ch7_sel_valid & route(channel7_request_select_reg, periph_req_i);

  // Pad mode outputs straight from registers
  // Bit 0 drives pin F3, bit 1 pin F4
  assign port_f_i2c_pad_select_o = pf_i2c_reg;
  // Bits 0 to 7 drive pins B6, B7, B8, B9, B10, B11, B13 and B14
  assign port_b_i2c_pad_select_o = pb_i2c_reg;
  // Bit 0 drives pin A9, bit 1 pin A10
  assign port_a_i2c_pad_select_o = pa_i2c_reg;

  // filter instances per port
  // Port A filters
  scfg_pin_filter #(
    .WIDTH(16),
    .CNT_W(CNT_W),
    .HOLD(HOLD)
  ) u_flt_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port_a_pin_i),
    .enable_i(flt_a_reg),
    .level_o(port_a_level_o)
  );

  // Port B filters
  scfg_pin_filter #(
    .WIDTH(16),
    .CNT_W(CNT_W),
    .HOLD(HOLD)
  ) u_flt_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port_b_pin_i),
    .enable_i(flt_b_reg),
    .level_o(port_b_level_o)
  );

  // Port C filters
  scfg_pin_filter #(
    .WIDTH(16),
    .CNT_W(CNT_W),
    .HOLD(HOLD)
  ) u_flt_c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port_c_pin_i),
    .enable_i(flt_c_reg),
    .level_o(port_c_level_o)
  );

  // Port F filters, pins 0 to 9 only
  scfg_pin_filter #(
    .WIDTH(`SCFG_FLT_F_W),
    .CNT_W(CNT_W),
    .HOLD(HOLD)
  ) u_flt_f (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(port_f_pin_i),
    .enable_i(flt_f_reg),
    .level_o(port_f_level_o)
  );
endmodule

// ===== src/scfg_consts.vh
// Offsets, field positions, reset values and timing counts of the configuration bank
`ifndef SCFG_CONSTS_VH
`define SCFG_CONSTS_VH
`define SCFG_ADDR_W 8
`define SCFG_OFS_DMA_SEL 8'h0C
`define SCFG_OFS_FLT_A 8'h10
`define SCFG_OFS_FLT_B 8'h14
`define SCFG_OFS_FLT_C 8'h18
`define SCFG_OFS_FLT_F 8'h1C
`define SCFG_OFS_I2C 8'h20
`define SCFG_CH7_LSB 16
`define SCFG_CH6_LSB 8
`define SCFG_CH5_LSB 0
`define SCFG_SEL_W 6
`define SCFG_SEL_RST 6'h3F
`define SCFG_SEL_MAX 6'h32
`define SCFG_DMA_SEL_RST 32'h003F3F3F
`define SCFG_FLT_RST 16'h0000
`define SCFG_FLT_F_W 10
`define SCFG_PF_I2C_LSB 24
`define SCFG_PB_I2C_LSB 8
`define SCFG_PA_I2C_LSB 0
`define SCFG_FILTER_NS 40
`define SCFG_CLK_MHZ 100
`define SCFG_FILTER_CYC ((`SCFG_FILTER_NS * `SCFG_CLK_MHZ + 999) / 1000)
`endif

// ===== src/scfg_pin_filter.v
// Per-pin input glitch filter with bypass
`timescale 1ns/1ns
module scfg_pin_filter #(
  parameter WIDTH = 16,
  parameter CNT_W = 4,
  parameter [CNT_W-1:0] HOLD = 4'h4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Pins and control
  input wire [WIDTH-1:0] pin_i,
  input wire [WIDTH-1:0] enable_i,
  output wire [WIDTH-1:0] level_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      reg sync1_reg;
      reg sync2_reg;
      reg filt_reg;
      reg [CNT_W-1:0] cnt_reg;
      // Two-stage synchroniser
      always @(posedge clk_i) begin
        if (rst_i) begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
        end else begin
          sync1_reg <= pin_i[g];
          sync2_reg <= sync1_reg;
        end
      end
      always @(posedge clk_i) begin
        if (rst_i) begin
          filt_reg <= 1'b0;
          cnt_reg <= {CNT_W{1'b0}};
        end else if (sync2_reg == filt_reg) begin
          cnt_reg <= {CNT_W{1'b0}};
        end else if (cnt_reg >= HOLD - 1'b1) begin
          filt_reg <= sync2_reg;
          cnt_reg <= {CNT_W{1'b0}};
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
      assign level_o[g] = enable_i[g] ? filt_reg : sync2_reg;
    end
  endgenerate
endmodule

// ===== bench/scfg_bank_props.sv
// Port-level checks of the configuration bank
`timescale 1ns/1ns
module scfg_bank_props #(
  parameter NREQ = 51
) (
  // Clock, reset and register port
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  // Routing, pads and pad modes
  input wire [NREQ-1:0] periph_req_i,
  input wire ch5_req_o,
  input wire ch6_req_o,
  input wire ch7_req_o,
  input wire [15:0] port_b_pin_i,
  input wire [15:0] port_b_level_o,
  input wire [1:0] port_f_i2c_pad_select_o,
  input wire [7:0] port_b_i2c_pad_select_o,
  input wire [1:0] port_a_i2c_pad_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Write then read of one filter register
  sequence s_flt_wr; wr_i && addr_i == 8'h10; endsequence
  sequence s_flt_rd; rd_i && !wr_i && addr_i == 8'h10; endsequence
  property p_readback; s_flt_wr ##1 s_flt_rd |=> rdata_o == {16'h0000, $past(wdata_i[15:0], 2)}; endproperty
  property p_idle; !rd_i |=> rdata_o == 32'h00000000; endproperty
  property p_unmapped; rd_i && (addr_i < 8'h0C || addr_i > 8'h20 || addr_i[1:0] != 2'h0) |=> rdata_o == 32'h0; endproperty
  property p_ch5; wr_i && addr_i == 8'h0C |=>
    ch5_req_o == ($past(wdata_i[5:0]) <= 6'h32 ? periph_req_i[$past(wdata_i[5:0])] : 1'b0); endproperty
  property p_ch6; wr_i && addr_i == 8'h0C |=>
    ch6_req_o == ($past(wdata_i[13:8]) <= 6'h32 ? periph_req_i[$past(wdata_i[13:8])] : 1'b0); endproperty
  property p_ch7; wr_i && addr_i == 8'h0C |=>
    ch7_req_o == ($past(wdata_i[21:16]) <= 6'h32 ? periph_req_i[$past(wdata_i[21:16])] : 1'b0); endproperty
  property p_pads; wr_i && addr_i == 8'h20 |=> {port_f_i2c_pad_select_o, port_b_i2c_pad_select_o,
    port_a_i2c_pad_select_o} == {$past(wdata_i[25:24]), $past(wdata_i[15:8]), $past(wdata_i[1:0])}; endproperty
  property p_reset; disable iff (1'b0) rst_i |=> rdata_o == 32'h0 && !ch5_req_o && !ch6_req_o && !ch7_req_o
    && port_f_i2c_pad_select_o == 2'h0 && port_b_i2c_pad_select_o == 8'h00 && port_a_i2c_pad_select_o == 2'h0; endproperty
  property p_settle; $stable(port_b_pin_i) [*8] |-> port_b_level_o == port_b_pin_i; endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ch5: assert property (p_ch5) else $error("channel 5 routing wrong");
  a_ch6: assert property (p_ch6) else $error("channel 6 routing wrong");
  a_ch7: assert property (p_ch7) else $error("channel 7 routing wrong");
  a_pads: assert property (p_pads) else $error("pad mode outputs wrong");
  a_reset: assert property (p_reset) else $error("outputs wrong after reset");
  a_settle: assert property (p_settle) else $error("steady pin not passed");
endmodule
bind scfg_bank scfg_bank_props #(.NREQ(NREQ)) i_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .periph_req_i(periph_req_i),
  .ch5_req_o(ch5_req_o), .ch6_req_o(ch6_req_o), .ch7_req_o(ch7_req_o), .port_b_pin_i(port_b_pin_i),
  .port_b_level_o(port_b_level_o), .port_f_i2c_pad_select_o(port_f_i2c_pad_select_o),
  .port_b_i2c_pad_select_o(port_b_i2c_pad_select_o), .port_a_i2c_pad_select_o(port_a_i2c_pad_select_o));

// ===== bench/testbench.sv
// Self-checking bench of the configuration bank
`timescale 1ns/1ns
module testbench;
  reg clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
  reg [7:0] addr_i = 8'h00, a, seen;
  reg [31:0] wdata_i = 32'h0, d, q[$], m[0:5];
  reg [50:0] req = 51'h0;
  reg [15:0] pin = 16'h0000, lf = 16'h974B;
  wire [31:0] rdata_o;
  wire [15:0] la, lb, lc;
  wire [9:0] lv;
  wire c5, c6, c7;
  integer failures = 0, checks_done = 0, i, k;
  // Clock
  always #5 clk_i = ~clk_i;
  scfg_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .periph_req_i(req), .ch5_req_o(c5), .ch6_req_o(c6), .ch7_req_o(c7),
    .port_a_pin_i(pin), .port_b_pin_i(pin), .port_c_pin_i(pin), .port_f_pin_i(pin[9:0]),
    .port_a_level_o(la), .port_b_level_o(lb), .port_c_level_o(lc), .port_f_level_o(lv),
    .port_f_i2c_pad_select_o(), .port_b_i2c_pad_select_o(), .port_a_i2c_pad_select_o());
  function [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // One bus cycle; a read notes its expected data
  task op(input w, input r, input [7:0] ad, input [31:0] dt);
    begin
      wr_i <= w;
      rd_i <= r;
      addr_i <= ad;
      wdata_i <= dt;
      if (r) q.push_back(dt);
      @(posedge clk_i);
    end
  endtask
  task look(input [31:0] e);
    begin
      // Write strobe lasts one cycle only
      wr_i <= 1'b0;
      @(negedge clk_i);
      chk("route", e, {29'h0, c7, c6, c5});
      @(posedge clk_i);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // Read data watcher
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) if (rd_d) chk("rdata", q.pop_front(), rdata_o);
  // Watchdog
  initial begin
    #30000;
    failures = failures + 1;
    close_out;
  end
  // Main sequence
  initial begin
    m[0] = 32'h003F3F3F; m[1] = 32'h0000FFFF; m[2] = 32'h0000FFFF;
    m[3] = 32'h0000FFFF; m[4] = 32'h000003FF; m[5] = 32'h0300FF03;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 6; i = i + 1) op(0, 1, 8'h0C + {i[5:0], 2'b00}, i ? 32'h0 : m[0]);
    op(1, 0, 8'h24, 32'hFFFFFFFF);
    op(0, 1, 8'h24, 32'h0);
    for (k = 0; k < 4; k = k + 1)
      for (i = 0; i < 6; i = i + 1) begin
        lf = nx(nx(lf));
        a = 8'h0C + {i[5:0], 2'b00};
        d = k ? {lf, nx(lf)} : 32'hFFFFFFFF;
        op(1, 0, a, d);
        op(0, 1, a, d & m[i]);
      end
    for (k = 0; k < 64; k = k + 1) begin
      op(1, 0, 8'h0C, {10'h000, k[5:0], 2'h0, k[5:0], 2'h0, k[5:0]});
      req <= 51'h1 << k;
      look(k < 51 ? 32'h7 : 32'h0);
      req <= ~(51'h1 << k);
      look(32'h0);
    end
    for (i = 1; i < 5; i = i + 1) op(1, 0, 8'h0C + {i[5:0], 2'b00}, 32'h1);
    op(0, 0, 8'h00, 32'h0);
    pin <= 16'h0003;
    repeat (3) @(posedge clk_i);
    pin <= 16'h0000;
    seen = 8'h00;
    repeat (10) @(negedge clk_i) seen = seen | {la[1:0], lb[1:0], lc[1:0], lv[1:0]};
    chk("glitch", 32'hAA, {24'h0, seen});
    @(posedge clk_i);
    pin <= 16'h0003;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    chk("level", 32'hFF, {24'h0, la[1:0], lb[1:0], lc[1:0], lv[1:0]});
    // Reset in mid-run brings every register back to its reset value
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 6; i = i + 1) op(0, 1, 8'h0C + {i[5:0], 2'b00}, i ? 32'h0 : m[0]);
    op(0, 0, 8'h00, 32'h0);
    close_out;
  end
endmodule
